// [tls_consts.svh]
// Purpose: Constants for the tamper and load supervisor
// Assumes: 100 MHz system clock
// Notes: Coefficients are unsigned Q0.16, thresholds scaled by 2^24
`ifndef TLS_CONSTS_SVH
`define TLS_CONSTS_SVH
`define TLS_CLK_PERIOD_NS 10
`define TLS_MUX_HALF 6'd32
`define TLS_MUX_TAMPER_LONG 6'd60
`define TLS_MUX_GAP 6'd4
`define TLS_WIN_LEN 6'd8
`define TLS_WIN_PRE 6'd4
`define TLS_TAMPER_CONFIRM 3'd4
`define TLS_STUCK_WINDOW 128
`define TLS_NOMINAL_COEFF_0 16'h5C01
`define TLS_NOMINAL_COEFF_1 16'h63FE
`define TLS_NOMINAL_COEFF_2 16'h6C01
`define TLS_NOMINAL_COEFF_3 16'h73FE
`define TLS_NL_COIL_BASE 32'h00012620
`define TLS_NL_CTSH_BASE 32'h0000EF13
`define TLS_TAMPER_CRITERION_SELECT_SHIFT_WIDE 3
`define TLS_TAMPER_CRITERION_SELECT_SHIFT_NARROW 4
`endif

// [tls_pkg.sv]
// Purpose: Types for the tamper and load supervisor
// Assumes: Included constants header
// Notes: None
package tls_pkg;
  typedef enum logic [1:0] {TLS_NORMAL, TLS_TAMPER_PRI, TLS_TAMPER_SEC} tls_state_t;
  typedef struct packed {
    logic [1:0] sensor_select;
    logic [1:0] nominal_voltage_select;
    logic [1:0] no_load_threshold_select;
    logic tamper_criterion_select;
    logic single_wire_enable;
  } tls_cfg_t;
  typedef struct packed {
    logic period_strobe;
    logic freq_range_error;
    logic signed [31:0] energy_pri;
    logic signed [31:0] energy_sec;
    logic [15:0] v_rms;
    logic [15:0] i_rms;
    logic [15:0] peak_line_voltage;
  } tls_dsp_t;
endpackage : tls_pkg

// [tls_supervisor.sv]
// Purpose: Tamper, no-load, stuck stream and pin mismatch supervision
// Assumes: DSP inputs synchronous to CLK_SYS; energies are per-period signed samples
// Notes: Stuck window counted in system clocks as a parameter
`timescale 1ns/1ps
`include "tls_consts.svh"
// Contract
// - Single-wire only with coil sensor select 0/1
// - Nominal voltage used while frequency error set
// - Apparent power: current RMS times scaled peak
// - Select picks one of four nominal coefficients
// - No-load flag when V*I below threshold
// - Four thresholds doubling, sensor-dependent base
// - No-load suspends integration, disables tamper
// - No-load blocks stepper, drives indicator low
// - Stuck sigma-delta streams replaced by toggling idle pattern
// - Flag output pin versus internal drive mismatch
// - Tamper criterion: difference exceeds factor times mean
// - Opposite signs keep tamper, pick higher power
// - Start normal, alternate channels 32:32 periods
// - Window four before switch, eight periods long
// - Tamper after four consecutive criterion hits
// - Tamper ratio 60:4 or 4:60, hold value
// - Gap samples other channel to change state
// - Tamper flag held, tamper pin low active
// - Bad inputs or no-load force normal state
// - Frequency error enables single-wire operation
module tls_supervisor #(
  parameter int SD_CH = 3,
  parameter int STUCK_WINDOW = `TLS_STUCK_WINDOW
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire tls_pkg::tls_cfg_t CFG,
  input wire tls_pkg::tls_dsp_t DSP,
  input wire logic [SD_CH-1:0] SD_IN,
  input wire logic [2:0] PIN_DRIVE,
  input wire logic [2:0] PIN_SENSE,
  output logic [SD_CH-1:0] SD_OUT,
  output logic [SD_CH-1:0] SD_STUCK,
  output logic PIN_ERROR,
  output logic NO_LOAD_FLAG,
  output logic NO_LOAD_OUT_PIN,
  output logic TAMPER_FLAG,
  output logic TAMPER_OUT_PIN,
  output logic SINGLE_WIRE_OPERATION,
  output logic CHANNEL_SEL_SEC,
  output logic [31:0] POWER_OUT,
  output logic INTEGRATION_SUSPEND,
  output logic STEPPER_BLOCK
);
  import tls_pkg::*;

  localparam int SW = $clog2(STUCK_WINDOW + 1);

  typedef struct packed {
    logic [SD_CH-1:0] sd_prev;
    logic [SD_CH-1:0] sd_out;
    logic [SD_CH-1:0] sd_stuck;
    logic [SW-1:0] stuck_cnt;
    logic [SD_CH-1:0] sd_toggled;
    logic pin_err;
    logic no_load;
    tls_state_t state;
    logic [5:0] per_cnt;
    logic sec_sel;
    logic [2:0] hits;
    logic signed [33:0] acc_a;
    logic signed [33:0] acc_b;
    logic [31:0] held_power;
    logic [31:0] power_out;
    logic tamper;
    logic single_wire_operation;
    logic suspend;
    logic step_block;
    logic nl_pin;
    logic tamper_pin;
  } tls_st_t;

  tls_st_t s_q, s_d;
  logic [1:0] rst_sync_q;
  logic rst_n;

  function automatic logic [15:0] nominal_coeff(input logic [1:0] sel);
    case (sel)
      2'd0: nominal_coeff = `TLS_NOMINAL_COEFF_0;
      2'd1: nominal_coeff = `TLS_NOMINAL_COEFF_1;
      2'd2: nominal_coeff = `TLS_NOMINAL_COEFF_2;
      default: nominal_coeff = `TLS_NOMINAL_COEFF_3;
    endcase
  endfunction : nominal_coeff

  function automatic logic [33:0] mag34(input logic signed [33:0] v);
    mag34 = v[33] ? 34'(-v) : v;
  endfunction : mag34

  // Only meaningful in the tamper states: true while the higher channel feeds energy
  function automatic logic long_phase(input tls_state_t st, input logic sec);
    long_phase = (st == TLS_TAMPER_PRI) ? !sec : sec;
  endfunction : long_phase

  function automatic logic [5:0] phase_len(input tls_state_t st, input logic sec);
    if (st == TLS_NORMAL)
      phase_len = `TLS_MUX_HALF;
    else if (long_phase(st, sec))
      phase_len = `TLS_MUX_TAMPER_LONG;
    else
      phase_len = `TLS_MUX_GAP;
  endfunction : phase_len

  function automatic logic eval_point(input tls_state_t st, input logic sec, input logic [5:0] cnt);
    if (st == TLS_NORMAL)
      eval_point = sec && (cnt == `TLS_WIN_PRE - 6'd1);
    else
      eval_point = !long_phase(st, sec) && (cnt == `TLS_MUX_GAP - 6'd1);
  endfunction : eval_point

  function automatic logic [33:0] abs_diff(input logic [33:0] a, input logic [33:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction : abs_diff

  // Factor times mean: sum/2 scaled by 1/8 or 1/16
  function automatic logic tamper_criterion_select_exceeded(input logic [33:0] diff, input logic [33:0] sum, input logic narrow);
    if (narrow)
      tamper_criterion_select_exceeded = diff > (sum >> (`TLS_TAMPER_CRITERION_SELECT_SHIFT_NARROW + 1));
    else
      tamper_criterion_select_exceeded = diff > (sum >> (`TLS_TAMPER_CRITERION_SELECT_SHIFT_WIDE + 1));
  endfunction : tamper_criterion_select_exceeded

  // A holds the long-phase channel, which is the secondary one in the secondary tamper state
  function automatic logic pri_is_higher(input tls_state_t st, input logic [33:0] mag_long,
                                         input logic [33:0] mag_other);
    if (st == TLS_TAMPER_SEC)
      pri_is_higher = mag_other > mag_long;
    else
      pri_is_higher = mag_long >= mag_other;
  endfunction : pri_is_higher

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  logic coil;
  logic [31:0] vi_prod;
  logic [31:0] app_power;
  logic [31:0] nl_thresh;
  logic [33:0] mag_a, mag_b, diff_ab, sum_ab;
  logic tamper_criterion_select_hit, opp_sign, bad_inputs, higher_pri;
  logic signed [31:0] e_cur;

  always_comb
  begin
    s_d = s_q;
    coil = (CFG.sensor_select < 2'd2);
    vi_prod = DSP.v_rms * DSP.i_rms;
    app_power = 32'((48'(DSP.i_rms) * 48'(32'(DSP.peak_line_voltage) * 32'(nominal_coeff(CFG.nominal_voltage_select)))) >> 16);
    nl_thresh = (coil ? `TLS_NL_COIL_BASE : `TLS_NL_CTSH_BASE) << CFG.no_load_threshold_select;
    mag_a = 34'h0;
    mag_b = 34'h0;
    diff_ab = 34'h0;
    sum_ab = 34'h0;
    tamper_criterion_select_hit = 1'b0;
    opp_sign = 1'b0;
    higher_pri = 1'b0;
    e_cur = s_q.sec_sel ? DSP.energy_sec : DSP.energy_pri;

    // Stuck stream check over a fixed window of system clocks
    s_d.sd_prev = SD_IN;
    s_d.sd_toggled = s_q.sd_toggled | (SD_IN ^ s_q.sd_prev);
    if (s_q.stuck_cnt == SW'(STUCK_WINDOW - 1))
    begin
      s_d.stuck_cnt = '0;
      s_d.sd_stuck = ~s_d.sd_toggled;
      s_d.sd_toggled = '0;
    end
    else
      s_d.stuck_cnt = s_q.stuck_cnt + SW'(1);
    for (int i = 0; i < SD_CH; i++)
      s_d.sd_out[i] = s_q.sd_stuck[i] ? s_q.stuck_cnt[0] : SD_IN[i];

    s_d.pin_err = |(PIN_DRIVE ^ PIN_SENSE);
    s_d.single_wire_operation = coil && CFG.single_wire_enable && DSP.freq_range_error;
    s_d.no_load = (s_d.single_wire_operation ? app_power : vi_prod) < nl_thresh;
    bad_inputs = DSP.freq_range_error || (|s_q.sd_stuck) || s_q.no_load;

    if (DSP.period_strobe)
    begin
      s_d.per_cnt = s_q.per_cnt + 6'd1;
      // A collects the primary channel in normal state, the long-phase channel in tamper states, B the other one
      if ((s_q.state == TLS_NORMAL) ? !s_q.sec_sel : long_phase(s_q.state, s_q.sec_sel))
      begin
        if (s_q.per_cnt >= phase_len(s_q.state, s_q.sec_sel) - `TLS_WIN_PRE)
          s_d.acc_a = s_q.acc_a + 34'(e_cur);
      end
      else if (s_q.per_cnt < `TLS_WIN_PRE)
        s_d.acc_b = s_q.acc_b + 34'(e_cur);

      if (s_q.state == TLS_NORMAL)
        s_d.power_out = 32'(e_cur);
      else if (long_phase(s_q.state, s_q.sec_sel))
      begin
        s_d.power_out = 32'(e_cur);
        s_d.held_power = 32'(e_cur);
      end
      else
        s_d.power_out = s_q.held_power;

      // Channel switching at the end of each multiplex phase
      if (s_q.per_cnt == phase_len(s_q.state, s_q.sec_sel) - 6'd1)
      begin
        s_d.per_cnt = 6'd0;
        s_d.sec_sel = !s_q.sec_sel;
      end

      // Criterion on the last sample of window B or of the gap
      if (eval_point(s_q.state, s_q.sec_sel, s_q.per_cnt))
      begin
        mag_a = mag34(s_d.acc_a);
        mag_b = mag34(s_d.acc_b);
        opp_sign = (s_d.acc_a[33] != s_d.acc_b[33]) && (s_d.acc_a != 34'sh0) && (s_d.acc_b != 34'sh0);
        diff_ab = abs_diff(mag_a, mag_b);
        sum_ab = mag_a + mag_b;
        tamper_criterion_select_hit = opp_sign || tamper_criterion_select_exceeded(diff_ab, sum_ab, CFG.tamper_criterion_select);
        higher_pri = pri_is_higher(s_q.state, mag_a, mag_b);
        s_d.acc_a = 34'sh0;
        s_d.acc_b = 34'sh0;
        if (s_q.state == TLS_NORMAL)
        begin
          s_d.hits = tamper_criterion_select_hit ? ((s_q.hits == `TLS_TAMPER_CONFIRM) ? s_q.hits : s_q.hits + 3'd1) : 3'd0;
          if (tamper_criterion_select_hit && s_q.hits == `TLS_TAMPER_CONFIRM - 3'd1)
          begin
            s_d.state = higher_pri ? TLS_TAMPER_PRI : TLS_TAMPER_SEC;
            s_d.tamper = 1'b1;
          end
        end
        else if (!tamper_criterion_select_hit)
        begin
          s_d.state = TLS_NORMAL;
          s_d.tamper = 1'b0;
          s_d.hits = 3'd0;
        end
        else
          s_d.state = higher_pri ? TLS_TAMPER_PRI : TLS_TAMPER_SEC;
        // Restart the multiplex so a tamper state begins with a full long phase, normal with the primary half
        if (s_d.state != TLS_NORMAL || s_q.state != TLS_NORMAL)
        begin
          s_d.per_cnt = 6'd0;
          s_d.sec_sel = (s_d.state == TLS_TAMPER_SEC);
        end
      end
    end

    if (bad_inputs)
    begin
      s_d.state = TLS_NORMAL;
      s_d.tamper = 1'b0;
      s_d.hits = 3'd0;
      s_d.acc_a = 34'sh0;
      s_d.acc_b = 34'sh0;
      // A tamper phase count can exceed the normal half, so restart it
      if (s_q.state != TLS_NORMAL)
      begin
        s_d.per_cnt = 6'd0;
        s_d.sec_sel = 1'b0;
      end
    end
    s_d.suspend = s_q.no_load || s_q.pin_err || (|s_q.sd_stuck) || (DSP.freq_range_error && !s_q.single_wire_operation);
    s_d.step_block = s_q.no_load;
    s_d.nl_pin = !s_d.step_block;
    s_d.tamper_pin = !s_d.tamper;
    if (s_d.single_wire_operation)
      s_d.power_out = app_power;
  end

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.state <= TLS_NORMAL;
      s_q.nl_pin <= 1'b1;
      s_q.tamper_pin <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign SD_OUT = s_q.sd_out;
  assign SD_STUCK = s_q.sd_stuck;
  assign PIN_ERROR = s_q.pin_err;
  assign NO_LOAD_FLAG = s_q.no_load;
  assign NO_LOAD_OUT_PIN = s_q.nl_pin;
  assign TAMPER_FLAG = s_q.tamper;
  assign TAMPER_OUT_PIN = s_q.tamper_pin;
  assign SINGLE_WIRE_OPERATION = s_q.single_wire_operation;
  assign CHANNEL_SEL_SEC = s_q.sec_sel;
  assign POWER_OUT = s_q.power_out;
  assign INTEGRATION_SUSPEND = s_q.suspend;
  assign STEPPER_BLOCK = s_q.step_block;
endmodule : tls_supervisor

// [tls_supervisor_chk.sv]
// Purpose: Port-level assertions for tls_supervisor
// Assumes: Design leaves reset two edges after RSTN rises
// Notes: live gates checks that need the synced reset released
`timescale 1ns/1ps
module tls_chk
  import tls_pkg::*;
#(
  parameter int SD_CH = 3
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire tls_pkg::tls_cfg_t CFG,
  input wire tls_pkg::tls_dsp_t DSP,
  input wire logic [2:0] PIN_DRIVE,
  input wire logic [2:0] PIN_SENSE,
  input wire logic [SD_CH-1:0] SD_STUCK,
  input wire logic PIN_ERROR,
  input wire logic NO_LOAD_FLAG,
  input wire logic NO_LOAD_OUT_PIN,
  input wire logic TAMPER_FLAG,
  input wire logic TAMPER_OUT_PIN,
  input wire logic SINGLE_WIRE_OPERATION,
  input wire logic INTEGRATION_SUSPEND,
  input wire logic STEPPER_BLOCK
);
  logic [1:0] up_q;
  logic live;
  always_ff @(posedge CLK_SYS or negedge RSTN)
    if (!RSTN)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  assign live = (up_q == 2'h3);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  a_nl_pin_low: assert property (NO_LOAD_FLAG |=> !NO_LOAD_OUT_PIN && STEPPER_BLOCK)
    else $error("no-load pin or stepper block wrong");
  a_nl_suspend: assert property (NO_LOAD_FLAG |=> INTEGRATION_SUSPEND)
    else $error("no-load did not suspend");
  a_nl_tamper_off: assert property (NO_LOAD_FLAG [*3] |-> !TAMPER_FLAG)
    else $error("tamper kept during no-load");
  a_pin_err_set: assert property (live && PIN_DRIVE != PIN_SENSE |=> PIN_ERROR)
    else $error("pin mismatch not flagged");
  a_pin_err_susp: assert property (PIN_ERROR |=> INTEGRATION_SUSPEND)
    else $error("pin error did not suspend");
  a_stuck_susp: assert property (|SD_STUCK |=> INTEGRATION_SUSPEND)
    else $error("stuck stream did not suspend");
  a_tamper_pin: assert property (TAMPER_OUT_PIN == !TAMPER_FLAG)
    else $error("tamper pin not inverse of flag");
  a_swm_gate: assert property (live |-> SINGLE_WIRE_OPERATION ==
    $past(!CFG.sensor_select[1] && CFG.single_wire_enable && DSP.freq_range_error))
    else $error("single-wire state wrong");
endmodule : tls_chk
bind tls_supervisor tls_chk #(.SD_CH(SD_CH)) u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CFG(CFG), .DSP(DSP),
  .PIN_DRIVE(PIN_DRIVE), .PIN_SENSE(PIN_SENSE), .SD_STUCK(SD_STUCK), .PIN_ERROR(PIN_ERROR),
  .NO_LOAD_FLAG(NO_LOAD_FLAG), .NO_LOAD_OUT_PIN(NO_LOAD_OUT_PIN), .TAMPER_FLAG(TAMPER_FLAG),
  .TAMPER_OUT_PIN(TAMPER_OUT_PIN), .SINGLE_WIRE_OPERATION(SINGLE_WIRE_OPERATION),
  .INTEGRATION_SUSPEND(INTEGRATION_SUSPEND), .STEPPER_BLOCK(STEPPER_BLOCK));

// [tls_supervisor_tb.sv]
// Purpose: Self-checking bench for tls_supervisor
// Assumes: Inputs change on falling edges
// Notes: Strobe every other cycle keeps tamper runs short
`timescale 1ns/1ps
`include "tls_consts.svh"
module tls_supervisor_tb;
  import tls_pkg::*;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic sd_run = 1'h1;
  tls_cfg_t cfg = '0;
  tls_dsp_t dsp = '0;
  logic [2:0] sd_in = 3'h0;
  logic [2:0] pin_drive = 3'h0;
  logic [2:0] pin_sense = 3'h0;
  logic [2:0] sd_out, sd_stuck, sd_prev;
  logic pin_err, nl_flag, nl_pin, t_flag, t_pin, single_wire_operation, sel_sec, susp, blk;
  logic [31:0] power;
  int fail_count = 0;
  int total_checks = 0;
  logic [15:0] kn [4] = '{`TLS_NOMINAL_COEFF_0, `TLS_NOMINAL_COEFF_1, `TLS_NOMINAL_COEFF_2, `TLS_NOMINAL_COEFF_3};
  tls_supervisor u_dut (.CLK_SYS(clk), .RSTN(rstn), .CFG(cfg), .DSP(dsp), .SD_IN(sd_in),
    .PIN_DRIVE(pin_drive), .PIN_SENSE(pin_sense), .SD_OUT(sd_out), .SD_STUCK(sd_stuck),
    .PIN_ERROR(pin_err), .NO_LOAD_FLAG(nl_flag), .NO_LOAD_OUT_PIN(nl_pin), .TAMPER_FLAG(t_flag),
    .TAMPER_OUT_PIN(t_pin), .SINGLE_WIRE_OPERATION(single_wire_operation), .CHANNEL_SEL_SEC(sel_sec),
    .POWER_OUT(power), .INTEGRATION_SUSPEND(susp), .STEPPER_BLOCK(blk));
  initial
    forever #5 clk = ~clk;
  // Live streams toggle so the stuck detector stays quiet
  always @(negedge clk)
    if (sd_run)
      sd_in <= ~sd_in;
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk32
  task automatic do_reset;
    rstn = 1'h0;
    repeat (20) @(negedge clk);
    rstn = 1'h1;
    repeat (3) @(negedge clk);
  endtask : do_reset
  // One cycle gap keeps strobes legal and lets answers settle
  task automatic strobes(input int n);
    repeat (n)
    begin
      @(negedge clk) dsp.period_strobe = 1'h1;
      @(negedge clk) dsp.period_strobe = 1'h0;
    end
    @(negedge clk);
  endtask : strobes
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("unexpected timeout");
    results();
  end
  initial
  begin
    cfg.single_wire_enable = 1'h1;
    dsp.v_rms = 16'hFFFF;
    dsp.i_rms = 16'hFFFF;
    dsp.energy_pri = 32'h000003E8;
    dsp.energy_sec = 32'h000003E8;
    do_reset();
    chk("tamper pin", 4'h1, t_pin);
    chk("no-load pin", 4'h1, nl_pin);
    for (int s = 0; s < 4; s++)
    begin
      cfg.no_load_threshold_select = s[1:0];
      dsp.i_rms = 16'h0010;
      dsp.v_rms = 16'((`TLS_NL_COIL_BASE >> 4) << s) - 16'h0001;
      repeat (4) @(negedge clk);
      chk("no-load flag", 4'h1, nl_flag);
      chk("no-load pin", 4'h0, nl_pin);
      chk("stepper block", 4'h1, blk);
      chk("suspend", 4'h1, susp);
      dsp.v_rms = 16'((`TLS_NL_COIL_BASE >> 4) << s);
      repeat (4) @(negedge clk);
      chk("no-load flag", 4'h0, nl_flag);
    end
    dsp.v_rms = 16'hFFFF;
    dsp.i_rms = 16'hFFFF;
    $display("test no-load done");
    dsp.freq_range_error = 1'h1;
    for (int s = 0; s < 4; s++)
    begin
      cfg.sensor_select = s[1:0];
      repeat (4) @(negedge clk);
      chk("single wire", {3'h0, s < 2}, single_wire_operation);
    end
    chk("suspend", 4'h1, susp);
    cfg.sensor_select = 2'h0;
    dsp.i_rms = 16'h0100;
    dsp.peak_line_voltage = 16'h0100;
    for (int n = 0; n < 4; n++)
    begin
      cfg.nominal_voltage_select = n[1:0];
      repeat (4) @(negedge clk);
      chk32("power", {16'h0000, kn[n]}, power);
    end
    dsp.i_rms = 16'hFFFF;
    dsp.freq_range_error = 1'h0;
    cfg.sensor_select = 2'h0;
    repeat (4) @(negedge clk);
    chk("single wire", 4'h0, single_wire_operation);
    $display("test single wire done");
    for (int b = 0; b < 3; b++)
    begin
      pin_sense = 3'h1 << b;
      repeat (3) @(negedge clk);
      chk("pin error", 4'h1, pin_err);
      chk("suspend", 4'h1, susp);
      pin_sense = 3'h0;
      repeat (3) @(negedge clk);
      chk("pin error", 4'h0, pin_err);
    end
    $display("test pin mismatch done");
    sd_run = 1'h0;
    repeat (300) @(negedge clk);
    chk("stuck", 4'h7, sd_stuck);
    chk("suspend", 4'h1, susp);
    sd_prev = sd_out;
    @(negedge clk);
    chk("idle stream", {1'h0, ~sd_prev}, sd_out);
    sd_run = 1'h1;
    repeat (300) @(negedge clk);
    chk("stuck", 4'h0, sd_stuck);
    $display("test stuck done");
    do_reset();
    strobes(31);
    chk("channel", 4'h0, sel_sec);
    chk32("power", 32'h000003E8, power);
    strobes(1);
    chk("channel", 4'h1, sel_sec);
    strobes(200);
    chk("tamper flag", 4'h0, t_flag);
    $display("test balanced done");
    dsp.energy_sec = 32'h00000384;
    do_reset();
    strobes(228);
    chk("tamper flag", 4'h0, t_flag);
    cfg.tamper_criterion_select = 1'h1;
    do_reset();
    strobes(228);
    chk("tamper flag", 4'h1, t_flag);
    cfg.tamper_criterion_select = 1'h0;
    $display("test criterion done");
    dsp.energy_sec = 32'h000001F4;
    do_reset();
    strobes(227);
    chk("tamper flag", 4'h0, t_flag);
    strobes(1);
    chk("tamper flag", 4'h1, t_flag);
    chk("tamper pin", 4'h0, t_pin);
    strobes(30);
    chk("channel", 4'h0, sel_sec);
    dsp.energy_sec = 32'hFFFFFE0C;
    strobes(64);
    chk("tamper flag", 4'h1, t_flag);
    chk("channel", 4'h0, sel_sec);
    dsp.v_rms = 16'h0000;
    repeat (5) @(negedge clk);
    chk("tamper flag", 4'h0, t_flag);
    $display("test tamper done");
    results();
  end
endmodule : tls_supervisor_tb
